// *** msi_vpd_capability_regs.sv ***
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ps
module msi_vpd_capability_regs
	import mvc_pkg::*;
#(
	parameter bit IS_UPSTREAM = 1'b1,
	parameter bit ADDR64_CAP  = 1'b1
)(
	input  wire logic                clk,
	input  wire logic                rstn,
	input  wire logic [AW-1:0]       addr,
	input  wire logic [31:0]         wdata,
	input  wire logic                wr,
	input  wire logic                rd,
	output logic [31:0]              rdata_q,
	input  wire logic                ee_ack,
	input  wire logic [31:0]         ee_rdata,
	output logic                     ee_req_q,
	output logic                     ee_we_q,
	output logic [PD_IDX_W-1:0]      ee_index_q,
	output logic [31:0]              ee_wdata_q,
	input  wire logic                autoload_valid,
	input  wire logic [TC_AL_W-1:0]  autoload_bits,
	output logic [63:0]              msi_target_q,
	output logic [MSI_DATA_W-1:0]    msi_payload_q,
	output logic                     msi_active_q,
	output logic                     intx_allowed_q,
	output logic                     role_change_en_q,
	output logic                     downstream_role_select_q,
	output logic                     hot_reset_block_q
);

	// ------------------------------------------------------------
	// Storage
	// ------------------------------------------------------------
	logic                  msi_en_q;
	logic [31:0]           msi_addr_q;
	logic [31:0]           msi_upper_q;
	logic [MSI_DATA_W-1:0] msi_data_q;
	logic [PD_IDX_W-1:0]   product_data_entry_index_q;
	logic                  product_data_write_permit_q;
	logic                  product_data_op_flag_q;
	logic [31:0]           pd_word_q;
	logic [31:0]           test_link_control_word_q;
	logic                  seq_busy;
	logic                  seq_done;
	logic [31:0]           seq_rdata;
	logic                  pd_start;
	logic                  pd_start_we;

	function automatic logic hit(input logic [AW-1:0] a,
		input logic [AW-1:0] off, input logic present);
		hit = present && (a == off);
	endfunction : hit

	// ------------------------------------------------------------
	// Table access start
	// ------------------------------------------------------------
	// Control writes while busy are dropped so the flag stays honest
	// write start
	assign pd_start_we = wdata[PD_OP_BIT] && wdata[PD_WE_BIT];
	// Completing access refuses a new start so flag and sequencer agree
	assign pd_start = wr && hit(addr, OFF_PD_CTRL, IS_UPSTREAM)
		&& !seq_busy && !seq_done
		&& (!wdata[PD_OP_BIT] || pd_start_we);

	mvc_eeprom_seq u_seq (
		.clk        (clk),
		.rstn       (rstn),
		.start      (pd_start),
		.write      (pd_start_we),
		.index      (wdata[PD_IDX_LSB +: PD_IDX_W]),
		.wdata      (pd_word_q),
		.ee_ack     (ee_ack),
		.ee_rdata   (ee_rdata),
		.ee_req_q   (ee_req_q),
		.ee_we_q    (ee_we_q),
		.ee_index_q (ee_index_q),
		.ee_wdata_q (ee_wdata_q),
		.busy_q     (seq_busy),
		.done_q     (seq_done),
		.rdata_q    (seq_rdata)
	);

	// ------------------------------------------------------------
	// Downstream interrupt registers
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			msi_en_q    <= 1'b0;
			msi_addr_q  <= 32'h00000000;
			msi_upper_q <= 32'h00000000;
			msi_data_q  <= '0;
		end else if (wr) begin
			if (hit(addr, OFF_MSI_CTRL, !IS_UPSTREAM)) begin
				msi_en_q <= wdata[MSI_EN_BIT];
			end
			if (hit(addr, OFF_MSI_ADDR, !IS_UPSTREAM)) begin
				msi_addr_q <= wdata & MSI_ADDR_MASK;
			end
			if (hit(addr, OFF_MSI_UPPER, !IS_UPSTREAM)) begin
				msi_upper_q <= wdata;
			end
			if (hit(addr, OFF_MSI_DATA, !IS_UPSTREAM)) begin
				msi_data_q <= wdata[MSI_DATA_W-1:0];
			end
		end
	end

	// ------------------------------------------------------------
	// Interrupt outputs
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			msi_target_q   <= 64'h0000000000000000;
			msi_payload_q  <= '0;
			msi_active_q   <= 1'b0;
			intx_allowed_q <= 1'b1;
		end else begin
			// upper half only when 64-bit capable
			msi_target_q  <= {ADDR64_CAP ? msi_upper_q : 32'h00000000,
				msi_addr_q};
			msi_payload_q <= msi_data_q;
			msi_active_q   <= msi_en_q;
			intx_allowed_q <= !msi_en_q;
		end
	end

	// ------------------------------------------------------------
	// Product-data control and word
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			product_data_entry_index_q  <= '0;
			product_data_write_permit_q <= 1'b0;
			product_data_op_flag_q      <= 1'b0;
		end else if (seq_done) begin
			product_data_op_flag_q <= !product_data_op_flag_q;
		end else if (wr && hit(addr, OFF_PD_CTRL, IS_UPSTREAM)
			&& !seq_busy) begin
			product_data_entry_index_q <= wdata[PD_IDX_LSB +: PD_IDX_W];
			product_data_write_permit_q <= wdata[PD_WE_BIT];
			product_data_op_flag_q <= wdata[PD_OP_BIT];
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			pd_word_q <= 32'h00000000;
		end else if (seq_done && !ee_we_q) begin
			pd_word_q <= seq_rdata;
		end else if (wr && hit(addr, OFF_PD_WORD, IS_UPSTREAM)
			&& !seq_busy) begin
			pd_word_q <= wdata;
		end
	end

	// ------------------------------------------------------------
	// Test link control word
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			test_link_control_word_q <= TEST_RST;
		end else if (wr && hit(addr, OFF_TEST_CTRL, 1'b1)) begin
			test_link_control_word_q <= wdata;
		end else if (autoload_valid) begin
			test_link_control_word_q[TC_AL_LSB +: TC_AL_W] <=
				autoload_bits;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			role_change_en_q         <= TEST_RST[TC_ROLE_EN_BIT];
			downstream_role_select_q <= TEST_RST[TC_ROLE_BIT];
			hot_reset_block_q        <= 1'b0;
		end else begin
			role_change_en_q <= test_link_control_word_q[TC_ROLE_EN_BIT];
			// role select, held while changes are barred
			if (test_link_control_word_q[TC_ROLE_EN_BIT]) begin
				downstream_role_select_q <=
					test_link_control_word_q[TC_ROLE_BIT];
			end
			hot_reset_block_q <= IS_UPSTREAM &&
				test_link_control_word_q[TC_HR_BLK_BIT];
		end
	end

	// ------------------------------------------------------------
	// Read path
	// ------------------------------------------------------------
	// Unmapped or absent registers read zero
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rdata_q <= 32'h00000000;
		end else if (!rd) begin
			rdata_q <= 32'h00000000;
		end else if (hit(addr, OFF_MSI_CTRL, !IS_UPSTREAM)) begin
			rdata_q <= (32'(ADDR64_CAP) << MSI_A64_BIT) |
				(32'(msi_en_q) << MSI_EN_BIT);
		end else if (hit(addr, OFF_MSI_ADDR, !IS_UPSTREAM)) begin
			rdata_q <= msi_addr_q;
		end else if (hit(addr, OFF_MSI_UPPER, !IS_UPSTREAM)) begin
			rdata_q <= msi_upper_q;
		end else if (hit(addr, OFF_MSI_DATA, !IS_UPSTREAM)) begin
			rdata_q <= 32'(msi_data_q);
		end else if (hit(addr, OFF_PD_CTRL, IS_UPSTREAM)) begin
			rdata_q <= {product_data_op_flag_q,
				product_data_write_permit_q, 6'h00,
				product_data_entry_index_q, 2'h0,
				PD_CAP_NEXT, PD_CAP_ID};
		end else if (hit(addr, OFF_PD_WORD, IS_UPSTREAM)) begin
			rdata_q <= pd_word_q;
		end else if (hit(addr, OFF_VEN_HDR, 1'b1)) begin
			rdata_q <= {VEN_CAP_LEN, VEN_CAP_NEXT, VEN_CAP_ID};
		end else if (hit(addr, OFF_TEST_CTRL, 1'b1)) begin
			rdata_q <= test_link_control_word_q;
		end else begin
			rdata_q <= 32'h00000000;
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	sequence s_pd_read_start;
		pd_start && !pd_start_we;
	endsequence

	sequence s_pd_finish;
		seq_done;
	endsequence

	a_msi_addr_low: assert property (
		@(posedge clk) disable iff (!rstn)
		rd && addr == OFF_MSI_ADDR |=> rdata_q[1:0] == 2'h0)
		else $error("interrupt address low bits not zero");

	a_upper_target: assert property (
		@(posedge clk) disable iff (!rstn)
		wr && addr == OFF_MSI_UPPER && !IS_UPSTREAM && ADDR64_CAP
		|=> ##1 msi_target_q[63:32] == $past(wdata, 2))
		else $error("upper target not taken");

	a_down_only_regs: assert property (
		@(posedge clk) disable iff (!rstn)
		rd && IS_UPSTREAM && addr == OFF_MSI_DATA |=> rdata_q == 0)
		else $error("downstream register seen on upstream port");

	a_pd_cap_hdr: assert property (
		@(posedge clk) disable iff (!rstn)
		rd && addr == OFF_PD_CTRL |=> rdata_q[15:0] ==
		(IS_UPSTREAM ? {PD_CAP_NEXT, PD_CAP_ID} : 16'h0000))
		else $error("product-data header wrong");

	a_pd_read_flag: assert property (
		@(posedge clk) disable iff (!rstn)
		s_pd_read_start |=> !product_data_op_flag_q && seq_busy)
		else $error("read start did not hold flag low");

	a_pd_flag_toggle: assert property (
		@(posedge clk) disable iff (!rstn)
		s_pd_finish |=> product_data_op_flag_q ==
		!$past(product_data_op_flag_q) && !seq_busy)
		else $error("flag did not toggle on completion");

	a_pd_word_fetch: assert property (
		@(posedge clk) disable iff (!rstn)
		s_pd_finish and !ee_we_q |=> pd_word_q == $past(seq_rdata))
		else $error("fetched word not kept");

	a_ven_hdr_read: assert property (
		@(posedge clk) disable iff (!rstn)
		rd && addr == OFF_VEN_HDR |=> rdata_q ==
		{VEN_CAP_LEN, VEN_CAP_NEXT, VEN_CAP_ID})
		else $error("vendor header wrong");

	a_role_locked: assert property (
		@(posedge clk) disable iff (!rstn)
		!test_link_control_word_q[TC_ROLE_EN_BIT]
		|=> $stable(downstream_role_select_q))
		else $error("role changed while barred");

	a_hot_reset_blk: assert property (
		@(posedge clk) disable iff (!rstn)
		##1 hot_reset_block_q == (IS_UPSTREAM &&
		$past(test_link_control_word_q[TC_HR_BLK_BIT])))
		else $error("hot reset block wrong");

	a_msi_excl: assert property (
		@(posedge clk) disable iff (!rstn)
		msi_active_q |-> !intx_allowed_q)
		else $error("pin and message interrupts both allowed");

	a_pd_busy_drop: assert property (
		@(posedge clk) disable iff (!rstn)
		wr && addr == OFF_PD_CTRL && (seq_busy || seq_done)
		|=> $stable(product_data_entry_index_q))
		else $error("control write taken during table access");

	a_pd_no_permit: assert property (
		@(posedge clk) disable iff (!rstn)
		wr && addr == OFF_PD_CTRL && wdata[PD_OP_BIT]
		&& !wdata[PD_WE_BIT] && !seq_busy |=> !ee_req_q)
		else $error("table access started without write permit");

	a_pd_index_out: assert property (
		@(posedge clk) disable iff (!rstn)
		pd_start |=> ee_index_q == product_data_entry_index_q)
		else $error("table index differs from control field");

	a_tc_autoload: assert property (
		@(posedge clk) disable iff (!rstn)
		autoload_valid && !(wr && addr == OFF_TEST_CTRL)
		|=> test_link_control_word_q[TC_AL_LSB +: TC_AL_W]
		== $past(autoload_bits))
		else $error("autoloaded bits not taken");

endmodule : msi_vpd_capability_regs

// *** msi_vpd_capability_regs_test.sv ***
`timescale 1ns/1ps
module msi_vpd_capability_regs_test;
	import mvc_pkg::*;
	logic        clk, rstn, wr, rd, slow, ack, al_v;
	logic [7:0]  addr;
	logic [31:0] wdata, ee_rd, up, dn, rd_u, rd_d, ee_wd;
	logic [1:0]  al_b;
	logic        req, we, act_d, intx_u, intx_d, rce, rsel, hrb_u, hrb_d;
	logic [5:0]  idx;
	logic [63:0] tgt_d;
	logic [15:0] pay_d;
	int          n_fail = 0;
	int          n_checks = 0;

	// ----------------------------------------
	// Upstream and downstream ports
	// ----------------------------------------
	msi_vpd_capability_regs #(.IS_UPSTREAM(1'b1)) dut_u (.clk(clk),
		.rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata_q(rd_u), .ee_ack(ack), .ee_rdata(ee_rd), .ee_req_q(req),
		.ee_we_q(we), .ee_index_q(idx), .ee_wdata_q(ee_wd),
		.autoload_valid(al_v), .autoload_bits(al_b), .msi_target_q(),
		.msi_payload_q(), .msi_active_q(), .intx_allowed_q(intx_u),
		.role_change_en_q(rce), .downstream_role_select_q(rsel),
		.hot_reset_block_q(hrb_u));
	msi_vpd_capability_regs #(.IS_UPSTREAM(1'b0)) dut_d (.clk(clk),
		.rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata_q(rd_d), .ee_ack(ack), .ee_rdata(ee_rd), .ee_req_q(),
		.ee_we_q(), .ee_index_q(), .ee_wdata_q(), .autoload_valid(al_v),
		.autoload_bits(al_b), .msi_target_q(tgt_d), .msi_payload_q(pay_d),
		.msi_active_q(act_d), .intx_allowed_q(intx_d),
		.role_change_en_q(), .downstream_role_select_q(),
		.hot_reset_block_q(hrb_d));
	mvc_table_model tbl_u (.clk(clk), .rstn(rstn), .req(req), .we(we),
		.index(idx), .wdata(ee_wd), .slow(slow), .ack(ack), .rdata(ee_rd));

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic chk(input string what, input logic [31:0] e,
		input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			n_fail++;
			$display("unexpected %s: expected %h seen %h", what, e, g);
		end
	endtask : chk

	task automatic wreg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		wr    <= 1'b1;
		addr  <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wreg

	task automatic rreg(input logic [7:0] a);
		@(posedge clk);
		rd   <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		up = rd_u;
		dn = rd_d;
	endtask : rreg

	// Bounded wait on the self-completing flag
	task automatic poll(input logic f);
		repeat (40) begin
			rreg(OFF_PD_CTRL);
			if (up[31] === f)
				break;
		end
		chk("op flag", {31'h0, f}, {31'h0, up[31]});
	endtask : poll

	task automatic end_sim;
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : end_sim

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset;
		chk("intx", 32'h3, {30'h0, intx_u, intx_d});
		rreg(OFF_PD_CTRL);
		chk("pd hdr", 32'h00006403, up & 32'hc003ffff);
		chk("pd dn", 32'h0, dn);
		rreg(OFF_VEN_HDR);
		chk("ven up", 32'h0034b009, up);
		chk("ven dn", 32'h0034b009, dn);
		rreg(OFF_TEST_CTRL);
		chk("test rst", 32'h04001060, up);
		rreg(OFF_MSI_UPPER);
		chk("upper", 32'h0, dn);
		rreg(OFF_MSI_CTRL);
		chk("cap64", 32'h1, {31'h0, dn[23]});
		$display("done reset values");
	endtask : t_reset

	task automatic t_msi;
		wreg(OFF_MSI_ADDR, 32'hffffffff);
		wreg(OFF_MSI_UPPER, 32'h12345678);
		wreg(OFF_MSI_DATA, 32'hffffffff);
		wreg(OFF_MSI_CTRL, 32'h00010000);
		wreg(OFF_VEN_HDR, 32'hffffffff);
		rreg(OFF_MSI_ADDR);
		chk("addr dn", 32'hfffffffc, dn);
		chk("addr up", 32'h0, up);
		rreg(OFF_MSI_DATA);
		chk("data dn", 32'h0000ffff, dn);
		rreg(OFF_VEN_HDR);
		chk("ven ro", 32'h0034b009, up);
		chk("tgt hi", 32'h12345678, tgt_d[63:32]);
		chk("tgt lo", 32'hfffffffc, tgt_d[31:0]);
		chk("payload", 32'h0000ffff, {16'h0, pay_d});
		chk("msi en", 32'h2, {30'h0, act_d, intx_d});
		$display("done message interrupt registers");
	endtask : t_msi

	task automatic t_read;
		slow <= 1'b1;
		wreg(OFF_PD_CTRL, 32'h00fc0000);
		@(posedge clk);
		#1;
		chk("req rd", 32'hbf, {24'h0, req, we, idx});
		wreg(OFF_PD_CTRL, 32'h80040000);
		rreg(OFF_PD_CTRL);
		chk("flag low", 32'h0, {31'h0, up[31]});
		chk("busy drop", 32'h3f, {26'h0, up[23:18]});
		poll(1'b1);
		rreg(OFF_PD_WORD);
		chk("word rd", 32'ha500003f, up);
		$display("done table read");
	endtask : t_read

	task automatic t_write;
		slow <= 1'b0;
		wreg(OFF_PD_WORD, 32'hdeadbeef);
		wreg(OFF_PD_CTRL, 32'hc0140000);
		@(posedge clk);
		#1;
		chk("req wr", 32'hc5, {24'h0, req, we, idx});
		chk("ee wdata", 32'hdeadbeef, ee_wd);
		poll(1'b0);
		wreg(OFF_PD_WORD, 32'h00000000);
		wreg(OFF_PD_CTRL, 32'h00140000);
		poll(1'b1);
		rreg(OFF_PD_WORD);
		chk("word back", 32'hdeadbeef, up);
		wreg(OFF_PD_CTRL, 32'h80080000);
		repeat (4) @(posedge clk);
		#1;
		chk("no permit", 32'h0, {31'h0, req});
		$display("done table write");
	endtask : t_write

	task automatic t_test;
		wreg(OFF_TEST_CTRL, 32'h0000000e);
		rreg(OFF_TEST_CTRL);
		chk("tc word", 32'h0000000e, up);
		chk("tc outs", 32'he, {28'h0, rce, rsel, hrb_u, hrb_d});
		wreg(OFF_TEST_CTRL, 32'h00000000);
		rreg(OFF_TEST_CTRL);
		chk("role hold", 32'h2, {29'h0, rce, rsel, hrb_u});
		wreg(OFF_TEST_CTRL, 32'h00000002);
		rreg(OFF_TEST_CTRL);
		chk("role up", 32'h2, {30'h0, rce, rsel});
		@(posedge clk);
		al_v <= 1'b1;
		al_b <= 2'b11;
		@(posedge clk);
		al_v <= 1'b0;
		rreg(OFF_TEST_CTRL);
		chk("autoload", 32'h00006002, up);
		$display("done test control word");
	endtask : t_test

	// ----------------------------------------
	// Clock, reset, sequence, watchdog
	// ----------------------------------------
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	initial begin
		{rstn, wr, rd, slow, al_v, al_b, addr, wdata} = '0;
		repeat (3) @(posedge clk);
		rstn <= 1'b1;
		t_reset();
		t_msi();
		t_read();
		t_write();
		t_test();
		end_sim();
	end

	// Whole run needs well under a thousand cycles
	initial begin
		#40000;
		n_fail++;
		end_sim();
	end
endmodule : msi_vpd_capability_regs_test

// *** mvc_eeprom_seq.sv ***
`timescale 1ns/1ps
module mvc_eeprom_seq
	import mvc_pkg::*;
(
	input  wire logic                clk,
	input  wire logic                rstn,
	input  wire logic                start,
	input  wire logic                write,
	input  wire logic [PD_IDX_W-1:0] index,
	input  wire logic [31:0]         wdata,
	input  wire logic                ee_ack,
	input  wire logic [31:0]         ee_rdata,
	output logic                     ee_req_q,
	output logic                     ee_we_q,
	output logic [PD_IDX_W-1:0]      ee_index_q,
	output logic [31:0]              ee_wdata_q,
	output logic                     busy_q,
	output logic                     done_q,
	output logic [31:0]              rdata_q
);

	mvc_seq_t state_q;

	// ------------------------------------------------------------
	// Request held until the table side answers
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state_q    <= SEQ_IDLE;
			ee_req_q   <= 1'b0;
			ee_we_q    <= 1'b0;
			ee_index_q <= '0;
			ee_wdata_q <= 32'h00000000;
			busy_q     <= 1'b0;
			done_q     <= 1'b0;
			rdata_q    <= 32'h00000000;
		end else begin
			done_q <= 1'b0;
			unique case (state_q)
				SEQ_IDLE: begin
					if (start) begin
						state_q    <= SEQ_WAIT;
						ee_req_q   <= 1'b1;
						ee_we_q    <= write;
						ee_index_q <= index;
						ee_wdata_q <= wdata;
						busy_q     <= 1'b1;
					end
				end
				SEQ_WAIT: begin
					// Ack seen only while request stands
					if (ee_ack) begin
						state_q  <= SEQ_IDLE;
						ee_req_q <= 1'b0;
						busy_q   <= 1'b0;
						done_q   <= 1'b1;
						if (!ee_we_q) begin
							rdata_q <= ee_rdata;
						end
					end
				end
			endcase
		end
	end

endmodule : mvc_eeprom_seq

// *** mvc_pkg.sv ***
package mvc_pkg;

	// ------------------------------------------------------------
	// Register offsets (byte addresses)
	// ------------------------------------------------------------
	localparam int unsigned AW = 8;
	localparam logic [7:0] OFF_MSI_CTRL   = 8'h4c;
	localparam logic [7:0] OFF_MSI_ADDR   = 8'h50;
	localparam logic [7:0] OFF_MSI_UPPER  = 8'h54;
	localparam logic [7:0] OFF_MSI_DATA   = 8'h58;
	localparam logic [7:0] OFF_PD_CTRL    = 8'h5c;
	localparam logic [7:0] OFF_PD_WORD    = 8'h60;
	localparam logic [7:0] OFF_VEN_HDR    = 8'h64;
	localparam logic [7:0] OFF_TEST_CTRL  = 8'h68;

	// ------------------------------------------------------------
	// Field positions and fixed values
	// ------------------------------------------------------------
	localparam int unsigned MSI_EN_BIT     = 16;
	localparam int unsigned MSI_A64_BIT    = 23;
	localparam logic [31:0] MSI_ADDR_MASK  = 32'hfffffffc;
	localparam int unsigned MSI_DATA_W     = 16;
	localparam int unsigned PD_IDX_LSB     = 18;
	localparam int unsigned PD_IDX_W       = 6;
	localparam int unsigned PD_WE_BIT      = 30;
	localparam int unsigned PD_OP_BIT      = 31;
	localparam logic [7:0]  PD_CAP_ID      = 8'h03;
	localparam logic [7:0]  PD_CAP_NEXT    = 8'h64;
	localparam logic [7:0]  VEN_CAP_ID     = 8'h09;
	localparam logic [7:0]  VEN_CAP_NEXT   = 8'hb0;
	localparam logic [15:0] VEN_CAP_LEN    = 16'h0034;
	localparam logic [31:0] TEST_RST       = 32'h04001060;
	localparam int unsigned TC_ROLE_EN_BIT = 1;
	localparam int unsigned TC_HR_BLK_BIT  = 2;
	localparam int unsigned TC_ROLE_BIT    = 3;
	localparam int unsigned TC_AL_LSB      = 13;
	localparam int unsigned TC_AL_W        = 2;

	// ------------------------------------------------------------
	// Table access sequencer states
	// ------------------------------------------------------------
	typedef enum logic {
		SEQ_IDLE,
		SEQ_WAIT
	} mvc_seq_t;

endpackage : mvc_pkg

// *** mvc_table_model.sv ***
`timescale 1ns/1ps
module mvc_table_model (
	input  wire logic        clk,
	input  wire logic        rstn,
	input  wire logic        req,
	input  wire logic        we,
	input  wire logic [5:0]  index,
	input  wire logic [31:0] wdata,
	input  wire logic        slow,
	output logic             ack,
	output logic [31:0]      rdata
);
	// ----------------------------------------
	// Serial table storage
	// ----------------------------------------
	logic [31:0] mem [64];
	logic [3:0]  cnt_q;
	logic        done_q;

	initial begin
		for (int i = 0; i < 64; i++)
			mem[i] = 32'ha5000000 | i;
	end

	// ----------------------------------------
	// Access timing, prompt or slow
	// ----------------------------------------
	// one ack per access
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cnt_q  <= 4'h0;
			done_q <= 1'b0;
			ack    <= 1'b0;
			rdata  <= 32'h0;
		end else begin
			ack   <= 1'b0;
			// Data line toggles every cycle between answers
			rdata <= ~rdata;
			if (!req) begin
				cnt_q  <= 4'h0;
				done_q <= 1'b0;
			end else if (!done_q && !ack) begin
				if (cnt_q >= (slow ? 4'h9 : 4'h1)) begin
					ack    <= 1'b1;
					done_q <= 1'b1;
					rdata  <= mem[index];
					if (we)
						mem[index] <= wdata;
				end else
					cnt_q <= cnt_q + 4'h1;
			end
		end
	end
endmodule : mvc_table_model
